// ### rtl/pcw_pkg.sv
// Constants, layouts and helper functions for the partitioned way selector.
// Behaviour
// RULE_01: Partitioning is active only while both way limits are above zero.
// RULE_02: Limits whose sum differs from the way count are accepted unchanged.
// RULE_03: Each index keeps two held counts, each within 0..ways, summing at most ways.
// RULE_04: A tag-updating hit on the other partition's way moves it and adjusts both counts.
// RULE_05: A miss with an empty way fills it for the requester, count may pass limit.
// RULE_06: Under the clamped limit, a full miss takes the other partition's oldest way.
// RULE_07: At or over the clamped limit, a full miss replaces the requester's oldest way.
// RULE_08: Over-limit counts never shrink by themselves, only via other-partition accesses.
// RULE_09: When inactive, a full miss evicts the oldest way of the index.
// RULE_10: Per-line partition tags are recorded even while partitioning is inactive.
// RULE_11: Uncacheable or non-translating accesses ignore the partition and raise nothing.
// RULE_12: The requester names the partition with one bit, zero or one.
// RULE_13: Data reads and prefetches retag a hit line with the latest partition.
// RULE_14: A per-index age order yields oldest way overall and per partition at once.
// RULE_15: Reset clears all held counts and marks every way empty.
package pcw_pkg;
   localparam int NWAY   = 4;
   localparam int WAY_W  = 2;
   localparam int IDX_W  = 4;
   localparam int NIDX   = 16;
   localparam int LIM_W  = 3;
   localparam int CNT_W  = 3;
   localparam int RANK_W = NWAY * WAY_W;
   localparam int VLD_POS  = 0;
   localparam int PART_POS = 4;
   localparam int RANK_POS = 8;
   localparam int H0_POS   = 16;
   localparam int H1_POS   = 19;
   localparam int WORD_W   = 22;
   localparam logic [CNT_W-1:0] NWAY_CNT = 3'h4;
   localparam logic [IDX_W-1:0] LAST_IDX = 4'hf;
   // Ranks start as a permutation so age order is always well formed.
   localparam logic [RANK_W-1:0] RANK_RST = 8'he4;
   localparam logic [WORD_W-1:0] WORD_RST = {6'h00, RANK_RST, 8'h00};

   typedef enum logic [1:0] {ST_CLEAR, ST_IDLE, ST_LOOK} pcw_state_e;

   function automatic logic [WAY_W-1:0] pcw_oldest(
      input logic [NWAY-1:0]   mask,
      input logic [RANK_W-1:0] rk);
      logic [WAY_W-1:0] best;
      logic [WAY_W-1:0] best_rank;
      logic             found;
      best      = '0;
      best_rank = '0;
      found     = 1'b0;
      for (int w = 0; w < NWAY; w++) begin
         if (mask[w] && (!found || rk[w*WAY_W +: WAY_W] > best_rank)) begin
            best      = WAY_W'(w);
            best_rank = rk[w*WAY_W +: WAY_W];
            found     = 1'b1;
         end
      end
      return best;
   endfunction

   function automatic logic [RANK_W-1:0] pcw_touch(
      input logic [RANK_W-1:0] rk,
      input logic [WAY_W-1:0]  way);
      logic [RANK_W-1:0] res;
      logic [WAY_W-1:0]  cur;
      res = rk;
      cur = rk[way*WAY_W +: WAY_W];
      for (int w = 0; w < NWAY; w++) begin
         if (WAY_W'(w) == way) begin
            res[w*WAY_W +: WAY_W] = '0;
         end else if (rk[w*WAY_W +: WAY_W] < cur) begin
            res[w*WAY_W +: WAY_W] = rk[w*WAY_W +: WAY_W] + 2'h1;
         end
      end
      return res;
   endfunction

   function automatic logic [WAY_W-1:0] pcw_first_empty(
      input logic [NWAY-1:0] vld);
      logic [WAY_W-1:0] res;
      res = '0;
      for (int w = NWAY - 1; w >= 0; w--) begin
         if (!vld[w]) begin
            res = WAY_W'(w);
         end
      end
      return res;
   endfunction
endpackage

// ### rtl/pcw_state_mem.sv
// Per-index replacement state storage with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module pcw_state_mem
   import pcw_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              we,
   input  wire logic [IDX_W-1:0]  waddr,
   input  wire logic [WORD_W-1:0] wdata,
   input  wire logic [IDX_W-1:0]  raddr,
   output var  logic [WORD_W-1:0] rdata_ff
);
   logic [WORD_W-1:0] mem [NIDX];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= WORD_RST;
      end else begin
         rdata_ff <= mem[raddr];
      end
   end
endmodule // pcw_state_mem
`default_nettype wire

// ### rtl/pcw_way_select.sv
// Victim-way selector for a two-partition set-associative cache.
`timescale 1ns/1ps
`default_nettype none
module pcw_way_select
   import pcw_pkg::*;
(
   input  wire logic             CLK,
   input  wire logic             RSTN,
   input  wire logic             REQ_VALID,
   input  wire logic [IDX_W-1:0] REQ_INDEX,
   input  wire logic             REQ_HIT,
   input  wire logic [WAY_W-1:0] REQ_HIT_WAY,
   input  wire logic             ACCESS_PARTITION_SELECT,
   input  wire logic             PAGE_CACHEABLE_ATTR,
   input  wire logic             REQ_TRANSLATING,
   input  wire logic             REQ_TAG_UPDATE,
   input  wire logic [LIM_W-1:0] PARTITION_ZERO_WAY_LIMIT,
   input  wire logic [LIM_W-1:0] PARTITION_ONE_WAY_LIMIT,
   output var  logic             READY,
   output var  logic             RESP_VALID,
   output var  logic             VICTIM_VALID,
   output var  logic             VICTIM_EVICT,
   output var  logic [WAY_W-1:0] VICTIM_WAY,
   output var  logic             PARTITION_ACTIVE,
   output var  logic [CNT_W-1:0] PARTITION_ZERO_WAYS_HELD,
   output var  logic [CNT_W-1:0] PARTITION_ONE_WAYS_HELD
);
   pcw_state_e        state_ff, nxt_state;
   logic [IDX_W-1:0]  clr_idx_ff, nxt_clr_idx;
   logic [IDX_W-1:0]  idx_ff, nxt_idx;
   logic              hit_ff, nxt_hit;
   logic [WAY_W-1:0]  hway_ff, nxt_hway;
   logic              sel_ff, nxt_sel;
   logic              ign_ff, nxt_ign;
   logic              tupd_ff, nxt_tupd;
   logic              ready_ff, nxt_ready;
   logic              resp_ff, nxt_resp;
   logic              vval_ff, nxt_vval;
   logic              evict_ff, nxt_evict;
   logic [WAY_W-1:0]  vway_ff, nxt_vway;
   logic              active_ff, nxt_active;
   logic [CNT_W-1:0]  h0_ff, nxt_h0;
   logic [CNT_W-1:0]  h1_ff, nxt_h1;

   logic              mem_we;
   logic [IDX_W-1:0]  mem_waddr;
   logic [WORD_W-1:0] mem_wdata;
   logic [WORD_W-1:0] mem_rdata;

   logic [NWAY-1:0]   cur_vld;
   logic [NWAY-1:0]   cur_part;
   logic [RANK_W-1:0] cur_rank;
   logic [CNT_W-1:0]  cur_h0;
   logic [CNT_W-1:0]  cur_h1;
   logic              act;
   logic [LIM_W-1:0]  lim_s;
   logic [CNT_W-1:0]  hs, ht;
   logic [NWAY-1:0]   smask, tmask;
   logic [WAY_W-1:0]  way;
   logic [NWAY-1:0]   new_vld;
   logic [NWAY-1:0]   new_part;
   logic              c_move, c_fill, c_steal, c_own, c_lru;

   pcw_state_mem u_mem (
      .clk      (CLK),
      .rst_n    (RSTN),
      .we       (mem_we),
      .waddr    (mem_waddr),
      .wdata    (mem_wdata),
      .raddr    (REQ_INDEX),
      .rdata_ff (mem_rdata)
   );

   assign cur_vld  = mem_rdata[VLD_POS  +: NWAY];
   assign cur_part = mem_rdata[PART_POS +: NWAY];
   assign cur_rank = mem_rdata[RANK_POS +: RANK_W];
   assign cur_h0   = mem_rdata[H0_POS   +: CNT_W];
   assign cur_h1   = mem_rdata[H1_POS   +: CNT_W];

   // Limits are used as given; no check of their sum against the way count.
   assign act = (PARTITION_ZERO_WAY_LIMIT != '0) &&
                (PARTITION_ONE_WAY_LIMIT != '0);   // RULE_01 RULE_02

   always_comb begin
      nxt_state   = state_ff;
      nxt_clr_idx = clr_idx_ff;
      nxt_idx     = idx_ff;
      nxt_hit     = hit_ff;
      nxt_hway    = hway_ff;
      nxt_sel     = sel_ff;
      nxt_ign     = ign_ff;
      nxt_tupd    = tupd_ff;
      nxt_ready   = ready_ff;
      nxt_resp    = 1'b0;
      nxt_vval    = vval_ff;
      nxt_evict   = evict_ff;
      nxt_vway    = vway_ff;
      nxt_active  = act;
      nxt_h0      = h0_ff;
      nxt_h1      = h1_ff;
      mem_we      = 1'b0;
      mem_waddr   = idx_ff;
      mem_wdata   = mem_rdata;
      lim_s       = sel_ff ? PARTITION_ONE_WAY_LIMIT
                           : PARTITION_ZERO_WAY_LIMIT;
      if (lim_s > LIM_W'(NWAY_CNT)) begin
         lim_s = LIM_W'(NWAY_CNT);
      end
      hs          = sel_ff ? cur_h1 : cur_h0;
      ht          = sel_ff ? cur_h0 : cur_h1;
      smask       = cur_vld & (sel_ff ? cur_part : ~cur_part);
      tmask       = cur_vld & (sel_ff ? ~cur_part : cur_part);
      way         = REQ_HIT_WAY;
      new_vld     = cur_vld;
      new_part    = cur_part;
      c_move      = 1'b0;
      c_fill      = 1'b0;
      c_steal     = 1'b0;
      c_own       = 1'b0;
      c_lru       = 1'b0;
      case (state_ff)
         ST_CLEAR: begin
            // Sweep every index back to empty before taking requests.
            mem_we      = 1'b1;
            mem_waddr   = clr_idx_ff;
            mem_wdata   = WORD_RST;   // RULE_15
            nxt_clr_idx = clr_idx_ff + 4'h1;
            if (clr_idx_ff == LAST_IDX) begin
               nxt_state = ST_IDLE;
               nxt_ready = 1'b1;
            end
         end
         ST_IDLE: begin
            if (REQ_VALID) begin
               nxt_idx   = REQ_INDEX;
               nxt_hit   = REQ_HIT;
               nxt_hway  = REQ_HIT_WAY;
               nxt_sel   = ACCESS_PARTITION_SELECT;   // RULE_12
               nxt_ign   = !PAGE_CACHEABLE_ATTR || !REQ_TRANSLATING;
               nxt_tupd  = REQ_TAG_UPDATE;
               nxt_ready = 1'b0;
               nxt_state = ST_LOOK;
            end
         end
         ST_LOOK: begin
            nxt_state = ST_IDLE;
            nxt_ready = 1'b1;
            nxt_resp  = 1'b1;
            nxt_evict = 1'b0;
            nxt_vval  = 1'b0;
            if (ign_ff) begin
               // Partition number is dropped; state is left untouched.
               nxt_vway = hway_ff;   // RULE_11
            end else begin
               if (hit_ff) begin
                  way = hway_ff;
                  if (tupd_ff && cur_vld[way] &&
                      (cur_part[way] != sel_ff)) begin
                     c_move = 1'b1;
                     hs     = hs + 3'h1;   // RULE_04
                     ht     = ht - 3'h1;   // RULE_04
                     new_part[way] = sel_ff;   // RULE_13
                  end
               end else begin
                  nxt_vval = 1'b1;
                  if (!(&cur_vld)) begin
                     c_fill = 1'b1;
                     way    = pcw_first_empty(cur_vld);
                     hs     = hs + 3'h1;   // RULE_05
                  end else if (!act) begin
                     c_lru     = 1'b1;
                     way       = pcw_oldest(cur_vld, cur_rank);   // RULE_09
                     nxt_evict = 1'b1;
                     if (cur_part[way] != sel_ff) begin
                        hs = hs + 3'h1;
                        ht = ht - 3'h1;
                     end
                  end else if (hs < CNT_W'(lim_s)) begin
                     c_steal   = 1'b1;
                     way       = pcw_oldest(tmask, cur_rank);   // RULE_06
                     nxt_evict = 1'b1;
                     hs        = hs + 3'h1;   // RULE_06
                     ht        = ht - 3'h1;   // RULE_06
                  end else begin
                     // Over-limit counts are kept; only own ways recycle.
                     c_own     = 1'b1;
                     way       = pcw_oldest(smask, cur_rank);   // RULE_07 RULE_08
                     nxt_evict = 1'b1;
                  end
                  new_vld[way]  = 1'b1;
                  new_part[way] = sel_ff;   // RULE_10
               end
               nxt_vway  = way;
               nxt_h0    = sel_ff ? ht : hs;   // RULE_03
               nxt_h1    = sel_ff ? hs : ht;   // RULE_03
               mem_we    = 1'b1;
               mem_wdata = {nxt_h1, nxt_h0,
                            pcw_touch(cur_rank, way),   // RULE_14
                            new_part, new_vld};
            end
            if (ign_ff) begin
               nxt_h0 = cur_h0;
               nxt_h1 = cur_h1;
            end
         end
         default: begin
            nxt_state = ST_CLEAR;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_ff   <= ST_CLEAR;
         clr_idx_ff <= '0;
         idx_ff     <= '0;
         hit_ff     <= 1'b0;
         hway_ff    <= '0;
         sel_ff     <= 1'b0;
         ign_ff     <= 1'b0;
         tupd_ff    <= 1'b0;
         ready_ff   <= 1'b0;
         resp_ff    <= 1'b0;
         vval_ff    <= 1'b0;
         evict_ff   <= 1'b0;
         vway_ff    <= '0;
         active_ff  <= 1'b0;
         h0_ff      <= '0;
         h1_ff      <= '0;
      end else begin
         state_ff   <= nxt_state;
         clr_idx_ff <= nxt_clr_idx;
         idx_ff     <= nxt_idx;
         hit_ff     <= nxt_hit;
         hway_ff    <= nxt_hway;
         sel_ff     <= nxt_sel;
         ign_ff     <= nxt_ign;
         tupd_ff    <= nxt_tupd;
         ready_ff   <= nxt_ready;
         resp_ff    <= nxt_resp;
         vval_ff    <= nxt_vval;
         evict_ff   <= nxt_evict;
         vway_ff    <= nxt_vway;
         active_ff  <= nxt_active;
         h0_ff      <= nxt_h0;
         h1_ff      <= nxt_h1;
      end
   end

   assign READY                    = ready_ff;
   assign RESP_VALID               = resp_ff;
   assign VICTIM_VALID             = vval_ff;
   assign VICTIM_EVICT             = evict_ff;
   assign VICTIM_WAY               = vway_ff;
   assign PARTITION_ACTIVE         = active_ff;
   assign PARTITION_ZERO_WAYS_HELD = h0_ff;
   assign PARTITION_ONE_WAYS_HELD  = h1_ff;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   sequence s_take;
      state_ff == ST_IDLE && REQ_VALID;
   endsequence
   sequence s_answer;
      ##2 RESP_VALID && READY;
   endsequence
   sequence s_look_ok;
      state_ff == ST_LOOK && !ign_ff;
   endsequence

   take_answer_a: assert property (s_take |-> s_answer)
      else $error("Request not answered two cycles after it was taken.");
   // The edge after reset release still shows the cleared flag, so skip it.
   active_flag_a: assert property ($past(RSTN) |->   // RULE_01
      PARTITION_ACTIVE == $past(act))
      else $error("Active flag does not follow the two limits.");
   count_bound_a: assert property (RESP_VALID |->   // RULE_03
      (4'(PARTITION_ZERO_WAYS_HELD) + 4'(PARTITION_ONE_WAYS_HELD)) <= 4'h4)
      else $error("Held counts exceed the way count.");
   hit_move_a: assert property (s_look_ok ##0 c_move |=>   // RULE_04
      (sel_ff ? PARTITION_ONE_WAYS_HELD : PARTITION_ZERO_WAYS_HELD)
         == $past(sel_ff ? cur_h1 : cur_h0) + 3'h1 && !VICTIM_VALID)
      else $error("Hit on other partition did not move the count.");
   empty_fill_a: assert property (s_look_ok ##0 c_fill |=>   // RULE_05
      VICTIM_VALID && !VICTIM_EVICT &&
      ((($past(cur_vld) >> VICTIM_WAY) & 4'h1) == 4'h0))
      else $error("Empty-way fill chose an occupied way.");
   steal_way_a: assert property (s_look_ok ##0 c_steal |=>   // RULE_06
      VICTIM_EVICT &&
      (((($past(cur_part) >> VICTIM_WAY) & 4'h1) == 4'h1) != $past(sel_ff)))
      else $error("Steal did not take the other partition's way.");
   own_way_a: assert property (s_look_ok ##0 c_own |=>   // RULE_07
      PARTITION_ZERO_WAYS_HELD == $past(cur_h0) &&
      PARTITION_ONE_WAYS_HELD == $past(cur_h1) &&
      (((($past(cur_part) >> VICTIM_WAY) & 4'h1) == 4'h1) == $past(sel_ff)))
      else $error("Own-way replacement changed counts or partition.");
   no_shrink_a: assert property (s_look_ok ##0 !sel_ff |=>   // RULE_08
      PARTITION_ZERO_WAYS_HELD >= $past(cur_h0))
      else $error("Partition zero count fell on its own access.");
   lru_pick_a: assert property (s_look_ok ##0 c_lru |=>   // RULE_09
      VICTIM_WAY == $past(pcw_oldest(cur_vld, cur_rank)) && VICTIM_EVICT)
      else $error("Inactive full miss did not evict the oldest way.");
   ignore_req_a: assert property (state_ff == ST_LOOK && ign_ff |=>   // RULE_11
      RESP_VALID && !VICTIM_VALID && !$past(mem_we))
      else $error("Ignored access changed state or chose a victim.");
   reset_clear_a: assert property (state_ff == ST_CLEAR |->   // RULE_15
      mem_we && mem_wdata == WORD_RST && !READY)
      else $error("Clear sweep did not write the empty state.");
endmodule // pcw_way_select
`default_nettype wire

// ### bench/pcw_pipe_model.sv
// Behavioural load/store pipeline that issues requests to the way selector.
`timescale 1ns/1ps
`default_nettype none
module pcw_pipe_model
   import pcw_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             ready,
   input  wire logic             resp_valid,
   input  wire logic             victim_valid,
   input  wire logic             victim_evict,
   input  wire logic [WAY_W-1:0] victim_way,
   input  wire logic [CNT_W-1:0] held0,
   input  wire logic [CNT_W-1:0] held1,
   output var  logic             req_valid,
   output var  logic [IDX_W-1:0] req_index,
   output var  logic             req_hit,
   output var  logic [WAY_W-1:0] req_hit_way,
   output var  logic             req_part,
   output var  logic             req_cach,
   output var  logic             req_trans,
   output var  logic             req_upd
);
   logic             got_resp;
   logic             got_vv;
   logic             got_ev;
   logic [WAY_W-1:0] got_way;
   logic [CNT_W-1:0] got_h0;
   logic [CNT_W-1:0] got_h1;

   initial begin
      req_valid = 1'b0;
      {req_index, req_hit, req_hit_way, req_part} = '0;
      {req_cach, req_trans, req_upd} = '0;
   end

   task automatic access(input logic [IDX_W-1:0] idx, input logic hit,
                         input logic [WAY_W-1:0] way, input logic part,
                         input logic cach, input logic trans,
                         input logic upd);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      // The partition travels as one select bit, zero or one.
      {req_index, req_hit, req_hit_way, req_part} <= {idx, hit, way, part};
      {req_cach, req_trans, req_upd} <= {cach, trans, upd};
      @(negedge clk);
      while (ready !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      // Released fields flip so a stale value is never mistaken for a live one.
      req_valid <= 1'b0;
      {req_index, req_hit, req_hit_way, req_part} <= ~{idx, hit, way, part};
      {req_cach, req_trans, req_upd} <= ~{cach, trans, upd};
      @(posedge clk);
      @(negedge clk);
      got_resp = resp_valid;
      {got_vv, got_ev, got_way} = {victim_valid, victim_evict, victim_way};
      {got_h0, got_h1} = {held0, held1};
   endtask
endmodule // pcw_pipe_model
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the partitioned way selector.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pcw_pkg::*;
;
   logic             CLK;
   logic             RSTN;
   logic [LIM_W-1:0] lim0;
   logic [LIM_W-1:0] lim1;
   logic             req_valid;
   logic [IDX_W-1:0] req_index;
   logic             req_hit;
   logic [WAY_W-1:0] req_hit_way;
   logic             req_part;
   logic             req_cach;
   logic             req_trans;
   logic             req_upd;
   logic             ready;
   logic             resp_valid;
   logic             vv;
   logic             ev;
   logic [WAY_W-1:0] vway;
   logic             active;
   logic [CNT_W-1:0] h0;
   logic [CNT_W-1:0] h1;
   int               mismatches;
   int               n_checks;

   pcw_way_select u_pcw_way_select (
      .CLK(CLK), .RSTN(RSTN), .REQ_VALID(req_valid), .REQ_INDEX(req_index),
      .REQ_HIT(req_hit), .REQ_HIT_WAY(req_hit_way),
      .ACCESS_PARTITION_SELECT(req_part), .PAGE_CACHEABLE_ATTR(req_cach),
      .REQ_TRANSLATING(req_trans), .REQ_TAG_UPDATE(req_upd),
      .PARTITION_ZERO_WAY_LIMIT(lim0), .PARTITION_ONE_WAY_LIMIT(lim1),
      .READY(ready), .RESP_VALID(resp_valid), .VICTIM_VALID(vv),
      .VICTIM_EVICT(ev), .VICTIM_WAY(vway), .PARTITION_ACTIVE(active),
      .PARTITION_ZERO_WAYS_HELD(h0), .PARTITION_ONE_WAYS_HELD(h1));

   pcw_pipe_model u_pcw_pipe_model (
      .clk(CLK), .ready(ready), .resp_valid(resp_valid),
      .victim_valid(vv), .victim_evict(ev), .victim_way(vway),
      .held0(h0), .held1(h1), .req_valid(req_valid), .req_index(req_index),
      .req_hit(req_hit), .req_hit_way(req_hit_way), .req_part(req_part),
      .req_cach(req_cach), .req_trans(req_trans), .req_upd(req_upd));

   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   task automatic end_sim;
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // One request, then the answer compared field by field.
   task automatic go(input logic [IDX_W-1:0] idx, input logic hit,
                     input logic [WAY_W-1:0] way, input logic part,
                     input logic cach, input logic trans, input logic upd,
                     input logic e_vv, input logic e_ev,
                     input logic [WAY_W-1:0] e_way,
                     input logic [CNT_W-1:0] e_h0,
                     input logic [CNT_W-1:0] e_h1);
      u_pcw_pipe_model.access(idx, hit, way, part, cach, trans, upd);
      chk(u_pcw_pipe_model.got_resp === 1'b1, "no answer pulse");
      chk(u_pcw_pipe_model.got_vv === e_vv, "victim valid");
      chk(u_pcw_pipe_model.got_ev === e_ev, "victim evict");
      chk(u_pcw_pipe_model.got_way === e_way, "victim way");
      chk(u_pcw_pipe_model.got_h0 === e_h0, "zero held count");
      chk(u_pcw_pipe_model.got_h1 === e_h1, "one held count");
   endtask

   task automatic limits(input logic [LIM_W-1:0] a, input logic [LIM_W-1:0] b);
      @(posedge CLK);
      lim0 <= a;
      lim1 <= b;
      repeat (2) @(posedge CLK);
      @(negedge CLK);
   endtask

   initial begin
      repeat (4000) @(posedge CLK);
      mismatches++;
      end_sim();
   end

   initial begin
      mismatches = 0;
      n_checks = 0;
      RSTN = 1'b0;
      lim0 = 3'h1;
      lim1 = 3'h1;
      repeat (6) @(posedge CLK);
      RSTN <= 1'b1;
      // The index sweep after reset keeps requests out for sixteen edges.
      repeat (16) begin
         @(negedge CLK);
         chk(ready === 1'b0, "ready during sweep");
      end
      @(negedge CLK);
      chk(ready === 1'b1, "ready after sweep");
      chk(active === 1'b1, "active with limits one");
      go(4'h3, 0, 2'h0, 1, 0, 1, 0, 0, 0, 2'h0, 3'h0, 3'h0);
      for (int i = 0; i < NWAY; i++) begin
         go(4'h3, 0, 2'h0, 0, 1, 1, 1, 1, 0, WAY_W'(i), CNT_W'(i + 1), 3'h0);
      end
      go(4'h3, 0, 2'h0, 1, 1, 1, 1, 1, 1, 2'h0, 3'h3, 3'h1);
      go(4'h3, 0, 2'h0, 1, 1, 1, 1, 1, 1, 2'h0, 3'h3, 3'h1);
      go(4'h3, 1, 2'h1, 1, 1, 1, 1, 0, 0, 2'h1, 3'h2, 3'h2);
      go(4'h3, 1, 2'h2, 1, 1, 1, 0, 0, 0, 2'h2, 3'h2, 3'h2);
      go(4'h3, 0, 2'h1, 1, 0, 1, 1, 0, 0, 2'h1, 3'h2, 3'h2);
      go(4'h3, 0, 2'h2, 1, 1, 0, 1, 0, 0, 2'h2, 3'h2, 3'h2);
      limits(3'h0, 3'h1);
      chk(active === 1'b0, "inactive with a zero limit");
      go(4'h3, 0, 2'h0, 1, 1, 1, 1, 1, 1, 2'h3, 3'h1, 3'h3);
      limits(3'h3, 3'h3);
      chk(active === 1'b1, "active with uneven sum");
      go(4'h3, 0, 2'h0, 0, 1, 1, 1, 1, 1, 2'h0, 3'h2, 3'h2);
      limits(3'h7, 3'h7);
      go(4'h3, 0, 2'h0, 1, 1, 1, 1, 1, 1, 2'h2, 3'h1, 3'h3);
      go(4'h5, 0, 2'h0, 1, 1, 1, 1, 1, 0, 2'h0, 3'h0, 3'h1);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
